// >>> hw/fofu_pkg.sv
// Constants and types shared by the operand format unit
package fofu_pkg;
   localparam int          WORK_W      = 64;      // Internal fraction width
   localparam int          EXP_W       = 8;       // Stored exponent width
   localparam int          EXPX_W      = 10;      // Widened exponent for shifts
   localparam int          SHORT_W     = 16;      // Short integer width
   localparam int          LONG_W      = 32;      // Long integer width
   localparam int          SGL_FRAC_W  = 23;      // Single fraction width
   localparam int          DBL_FRAC_W  = 55;      // Double fraction width
   localparam int          SGL_PAD_W   = 39;      // Zero fill below single fraction
   localparam int          DBL_PAD_W   = 7;       // Zero fill below double fraction
   localparam int          OVF_BIT     = 63;      // Fraction overflow bit
   localparam int          HID_BIT     = 62;      // Hidden bit
   localparam logic [7:0]  EXP_BIAS    = 8'h80;   // Excess two hundred octal
   localparam logic [7:0]  EXP_ZERO    = 8'h00;   // Most negative exponent code
   localparam logic [1:0]  NORM_TOP    = 2'h1;    // Bits 63:62 when normalized
   localparam logic [9:0]  SHORT_EXP   = 10'h08f; // Bias plus fifteen
   localparam logic [9:0]  LONG_EXP    = 10'h09f; // Bias plus thirty one
   localparam logic [9:0]  MAX_SHIFT   = 10'h03f; // Largest fraction shift

   // Sequencer states
   typedef enum logic [0:0]
   {
      FOFU_IDLE = 1'b0,
      FOFU_NORM = 1'b1
   } fofu_state_type;
endpackage : fofu_pkg

// >>> hw/fofu_normalizer.sv
// Combinational normalizer for the internal working fraction
module fofu_normalizer
   import fofu_pkg::*;
(
   input  wire logic [WORK_W-1:0] i_frac,   // Raw fraction
   input  wire logic [EXPX_W-1:0] i_exp,    // Biased exponent, widened
   output logic      [WORK_W-1:0] o_frac,   // Normalized fraction
   output logic      [EXPX_W-1:0] o_exp,    // Adjusted exponent
   output logic                   o_zero    // Fraction was zero
);
   logic [EXPX_W-1:0] lead;                 // Leading zeros below bit 63
   logic              found;                // A one seen while scanning

   // Count leading zeros from the hidden bit down
   always_comb
   begin
      lead  = '0;
      found = 1'b0;
      for (int k = HID_BIT; k >= 0; k--)
      begin
         if (!found && i_frac[k])
         begin
            found = 1'b1;
            lead  = EXPX_W'(HID_BIT - k);
         end
      end
   end

   // Overflow shifts right once, otherwise shift left out the zeros
   always_comb
   begin
      o_zero = (i_frac == '0);
      if (i_frac[OVF_BIT])
      begin
         o_frac = i_frac >> 1;                       // RULE9
         o_exp  = i_exp + EXPX_W'(1);                // RULE9
      end
      else if (o_zero)
      begin
         o_frac = '0;
         o_exp  = '0;
      end
      else
      begin
         o_frac = i_frac << lead;                    // RULE8
         o_exp  = i_exp - lead;                      // RULE8
      end
   end
endmodule : fofu_normalizer

// >>> hw/fofu_format_unit.sv
// Operand pack and unpack datapath of the floating coprocessor
//
// Summary of operation
// RULE1: Short 16 and long 32 bit integers
// RULE2: Integers are two's complement, top bit sign
// RULE3: Single 32 and double 64 bit floats
// RULE4: Top bit sign, next eight biased exponent
// RULE5: Sign-magnitude fraction, 23 or 55 bits
// RULE6: Unpack keeps sign, exponent, fraction bits
// RULE7: Negate flips the sign bit only
// RULE8: Normalize so bit63 zero, bit62 one
// RULE9: Overflow bit: shift right, exponent plus one
// RULE10: Hidden bit dropped on store, restored load
// RULE11: Stored exponent is true plus octal 200
// RULE12: Most negative exponent code means zero
// RULE13: Outputs are status flags or memory words
// RULE14: Double select picks 64 or 32 float
// RULE15: Long select picks 32 or 16 integer
// RULE16: Single fills low fraction zeros, store drops
// RULE17: Fixed latency, reset clears working word
module fofu_format_unit
   import fofu_pkg::*;
(
   input  wire logic              i_sys_clk,                // System clock
   input  wire logic              i_rst,                    // Synchronous reset
   input  wire logic              i_double_precision_select, // Float width mode
   input  wire logic              i_long_integer_select,    // Integer width mode
   input  wire logic              i_unpack_float,           // Load float word
   input  wire logic              i_unpack_int,             // Load integer word
   input  wire logic              i_arith_load,             // Load arithmetic result
   input  wire logic              i_negate,                 // Flip sign
   input  wire logic              i_pack_float,             // Store float word
   input  wire logic              i_pack_int,               // Store integer word
   input  wire logic [WORK_W-1:0] i_mem_word,               // Word from memory
   input  wire logic              i_arith_sign,             // Result sign
   input  wire logic [EXP_W-1:0]  i_arith_exp,              // Result exponent
   input  wire logic [WORK_W-1:0] i_arith_frac,             // Result fraction
   output logic                   o_ready,                  // Accepts a command
   output logic                   o_done,                   // Working word updated
   output logic                   o_work_sign,              // Working sign
   output logic      [EXP_W-1:0]  o_work_exp,               // Working exponent
   output logic      [WORK_W-1:0] o_work_frac,              // Working fraction
   output logic                   o_zero,                   // Status: value is zero
   output logic                   o_negative,               // Status: value negative
   output logic      [WORK_W-1:0] o_mem_word,               // Word to memory
   output logic                   o_mem_valid               // Word to memory valid
);
   fofu_state_type    state;              // Sequencer state
   fofu_state_type    next_state;         // Next sequencer state
   logic              pend_sign;          // Staged sign
   logic [EXPX_W-1:0] pend_exp;           // Staged exponent
   logic [WORK_W-1:0] pend_frac;          // Staged fraction
   logic [WORK_W-1:0] norm_frac;          // Normalizer fraction
   logic [EXPX_W-1:0] norm_exp;           // Normalizer exponent
   logic              norm_zero;          // Normalizer zero flag

   // Command selection, one at a time in fixed priority
   wire take_uf  = o_ready && i_unpack_float;
   wire take_ui  = o_ready && !i_unpack_float && i_unpack_int;
   wire take_ar  = o_ready && !i_unpack_float && !i_unpack_int && i_arith_load;
   wire any_load = take_uf || take_ui || take_ar;
   wire take_ng  = o_ready && !any_load && i_negate;
   wire take_pf  = o_ready && !any_load && !i_negate && i_pack_float;
   wire take_pi  = o_ready && !any_load && !i_negate && !i_pack_float && i_pack_int;

   // Float field decode from memory word
   wire              dbl      = i_double_precision_select;                 // RULE14
   wire              f_sign   = dbl ? i_mem_word[63] : i_mem_word[31];     // RULE4
   wire [EXP_W-1:0]  f_exp    = dbl ? i_mem_word[62:55] : i_mem_word[30:23]; // RULE4
   wire              f_is_zero = (f_exp == EXP_ZERO);                       // RULE12
   wire [WORK_W-1:0] f_frac_d = {NORM_TOP, i_mem_word[DBL_FRAC_W-1:0],
                                 {DBL_PAD_W{1'b0}}};                       // RULE10
   wire [WORK_W-1:0] f_frac_s = {NORM_TOP, i_mem_word[SGL_FRAC_W-1:0],
                                 {SGL_PAD_W{1'b0}}};                       // RULE16
   wire [WORK_W-1:0] f_frac   = f_is_zero ? '0 : (dbl ? f_frac_d : f_frac_s); // RULE5

   // Integer decode, short words sign extended first
   wire              lng      = i_long_integer_select;                     // RULE15
   wire [LONG_W-1:0] i_val    = lng ? i_mem_word[LONG_W-1:0]
                              : {{SHORT_W{i_mem_word[SHORT_W-1]}}, i_mem_word[SHORT_W-1:0]};
   wire              i_sign   = i_val[LONG_W-1];                           // RULE2
   wire [LONG_W-1:0] i_mag    = i_sign ? (~i_val + LONG_W'(1)) : i_val;    // RULE2
   wire [WORK_W-1:0] i_frac   = lng ? {i_mag, {LONG_W{1'b0}}}
                              : {i_mag[SHORT_W-1:0], {(WORK_W-SHORT_W){1'b0}}}; // RULE1
   wire [EXPX_W-1:0] i_exp    = lng ? LONG_EXP : SHORT_EXP;               // RULE11

   // Float encode of the working word, hidden bit dropped
   wire [WORK_W-1:0] pf_word  = dbl
      ? {o_work_sign, o_work_exp, o_work_frac[HID_BIT-1:DBL_PAD_W]}         // RULE10
      : {{LONG_W{1'b0}}, o_work_sign, o_work_exp,
         o_work_frac[HID_BIT-1:SGL_PAD_W]};                                // RULE16

   // Integer encode: shift fraction by true exponent, apply sign
   wire [EXPX_W-1:0] true_exp = {2'b00, o_work_exp} - {2'b00, EXP_BIAS};   // RULE11
   wire              t_neg    = true_exp[EXPX_W-1] || (o_work_exp == EXP_ZERO); // RULE12
   wire              t_big    = !t_neg && (true_exp > MAX_SHIFT);
   wire [EXPX_W-1:0] sh_amt   = t_big ? '0 : (MAX_SHIFT - true_exp);
   wire [WORK_W-1:0] pi_mag   = t_neg ? '0 : (o_work_frac >> sh_amt);
   wire [WORK_W-1:0] pi_val   = o_work_sign ? (~pi_mag + WORK_W'(1)) : pi_mag; // RULE2
   wire [WORK_W-1:0] pi_word  = lng ? {{LONG_W{1'b0}}, pi_val[LONG_W-1:0]}
                              : {{(WORK_W-SHORT_W){1'b0}}, pi_val[SHORT_W-1:0]}; // RULE1

   // Shared normalizer on staged operand
   fofu_normalizer u_norm
   (
      .i_frac (pend_frac),
      .i_exp  (pend_exp),
      .o_frac (norm_frac),
      .o_exp  (norm_exp),
      .o_zero (norm_zero)
   );

   // Handshake and status outputs
   assign o_ready    = (state == FOFU_IDLE);
   assign o_zero     = (o_work_frac == '0);                                // RULE13
   assign o_negative = o_work_sign && !o_zero;                             // RULE13

   // Next state: loads take one normalize cycle
   always_comb
   begin
      case (state)
         FOFU_IDLE: next_state = any_load ? FOFU_NORM : FOFU_IDLE;         // RULE17
         FOFU_NORM: next_state = FOFU_IDLE;
         default:   next_state = FOFU_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         state <= FOFU_IDLE;
      else
         state <= next_state;
   end

   // Staging of the operand to normalize
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         pend_sign <= 1'b0;
         pend_exp  <= '0;
         pend_frac <= '0;
      end
      else if (take_uf)
      begin
         pend_sign <= f_sign;                                              // RULE6
         pend_exp  <= {2'b00, f_exp};                                      // RULE6
         pend_frac <= f_frac;                                              // RULE6
      end
      else if (take_ui)
      begin
         pend_sign <= i_sign;
         pend_exp  <= i_exp;
         pend_frac <= i_frac;
      end
      else if (take_ar)
      begin
         pend_sign <= i_arith_sign;
         pend_exp  <= {2'b00, i_arith_exp};
         pend_frac <= i_arith_frac;
      end
   end

   // Working word: normalized result or sign flip
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         o_work_sign <= 1'b0;                                              // RULE17
         o_work_exp  <= '0;                                                // RULE17
         o_work_frac <= '0;                                                // RULE17
      end
      else if (state == FOFU_NORM)
      begin
         o_work_sign <= norm_zero ? 1'b0 : pend_sign;
         o_work_exp  <= norm_exp[EXP_W-1:0];
         o_work_frac <= norm_frac;
      end
      else if (take_ng)
         o_work_sign <= ~o_work_sign;                                      // RULE7
   end

   // Completion pulse and memory word register
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         o_done      <= 1'b0;
         o_mem_valid <= 1'b0;
         o_mem_word  <= '0;
      end
      else
      begin
         o_done      <= (state == FOFU_NORM) || take_ng;
         o_mem_valid <= take_pf || take_pi;                                // RULE13
         if (take_pf)
            o_mem_word <= pf_word;                                         // RULE3
         else if (take_pi)
            o_mem_word <= pi_word;                                         // RULE1
      end
   end

   // Helper copies of the last memory word and arithmetic input
   logic [WORK_W-1:0] chk_word;
   logic [WORK_W-1:0] chk_frac;
   logic [EXP_W-1:0]  chk_exp;
   always_ff @(posedge i_sys_clk)
   begin
      chk_word <= i_mem_word;
      chk_frac <= i_arith_frac;
      chk_exp  <= i_arith_exp;
   end

   // Checks on the datapath
   fixed_latency_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE17
      any_load |=> !o_ready ##1 o_done && o_ready)
      else $error("Load did not finish in two cycles");
   reset_clear_a: assert property (@(posedge i_sys_clk) // RULE17
      i_rst |=> o_work_frac == '0 && o_work_exp == '0 && !o_work_sign)
      else $error("Reset left working word set");
   norm_form_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE8
      $rose(o_done) && !o_zero && $past(state) == FOFU_NORM |->
      o_work_frac[OVF_BIT:HID_BIT] == NORM_TOP)
      else $error("Fraction not normalized");
   ovf_shift_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE9
      take_ar && i_arith_frac[OVF_BIT] |=> ##1
      o_work_frac == ($past(chk_frac) >> 1) && o_work_exp == $past(chk_exp) + EXP_W'(1))
      else $error("Overflow not shifted right");
   dbl_fields_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE6
      take_uf && dbl && !f_is_zero |=> ##1
      o_work_sign == $past(chk_word[63]) && o_work_exp == $past(chk_word[62:55])
      && o_work_frac[HID_BIT] && o_work_frac[HID_BIT-1:DBL_PAD_W] == $past(chk_word[54:0]))
      else $error("Double unpack changed fields");
   zero_exp_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE12
      take_uf && f_is_zero |=> ##1 o_zero && !o_negative)
      else $error("Zero exponent not read as zero");
   negate_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE7
      take_ng |=> o_work_sign != $past(o_work_sign) && $stable(o_work_exp)
      && $stable(o_work_frac))
      else $error("Negate touched more than sign");
   pack_dbl_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE10
      take_pf && dbl |=> o_mem_valid
      && o_mem_word == {o_work_sign, o_work_exp, o_work_frac[HID_BIT-1:DBL_PAD_W]})
      else $error("Double pack word wrong");
   pack_sgl_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE16
      take_pf && !dbl |=> o_mem_word[WORK_W-1:LONG_W] == '0
      && o_mem_word[SGL_FRAC_W-1:0] == o_work_frac[HID_BIT-1:SGL_PAD_W])
      else $error("Single pack word wrong");
   short_int_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE15
      take_pi && !lng |=> o_mem_valid && o_mem_word[WORK_W-1:SHORT_W] == '0)
      else $error("Short integer wider than sixteen bits");

   unpack_dbl_c: cover property (@(posedge i_sys_clk) take_uf && dbl ##2 o_done);
   int_round_c:  cover property (@(posedge i_sys_clk) take_ui && i_sign ##3 take_pi);
   ovf_c:        cover property (@(posedge i_sys_clk) take_ar && i_arith_frac[OVF_BIT]);
endmodule : fofu_format_unit

// >>> sim/fofu_host_model.sv
// Host side model that hands operand words in and collects stored words
module fofu_host_model
   import fofu_pkg::*;
(
   input  wire logic              i_sys_clk,    // System clock
   input  wire logic              i_rst,        // Synchronous reset
   input  wire logic [WORK_W-1:0] i_operand,    // Operand fetched from memory
   input  wire logic [WORK_W-1:0] i_store_word, // Word leaving the unit
   input  wire logic              i_store_valid, // Store strobe from the unit
   output logic      [WORK_W-1:0] o_load_word,  // Word presented to the unit
   output logic      [WORK_W-1:0] o_captured    // Last word written to memory
);
   timeunit 1ns;
   timeprecision 1ps;

   // Operands always handed over as one complete word
   assign o_load_word = i_operand;

   // Memory write: whole word taken on the store strobe
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         o_captured <= '0;
      end
      else if (i_store_valid)
      begin
         o_captured <= i_store_word;
      end
   end
endmodule : fofu_host_model

// >>> sim/fofu_format_unit_tb.sv
// Self-checking bench for the operand format unit
module fofu_format_unit_tb
   import fofu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0, rst = 1'b1, dp = 1'b0, li = 1'b0, ar_s = 1'b0;
   logic [5:0]  cmd_v = '0;              // {ufl, uint, arith, neg, pfl, pint}
   logic [7:0]  ar_e = '0, e, ne;        // Exponents
   logic [63:0] op = '0, ar_f = '0, w, f, m, nf, mem, captured;
   logic signed [31:0] v;                // Integer operand
   logic        s, o_ready, o_done, o_sign, o_zero, o_neg, o_mval;
   logic [7:0]  o_exp;
   logic [63:0] o_frac, o_mword, load_word;
   int fails = 0, tests_run = 0, cycles = 0, seed = 98;

   always #5 clk = ~clk;                  // 100 MHz clock

   fofu_format_unit u_dut (.i_sys_clk(clk), .i_rst(rst), .i_double_precision_select(dp),
      .i_long_integer_select(li), .i_unpack_float(cmd_v[5]), .i_unpack_int(cmd_v[4]),
      .i_arith_load(cmd_v[3]), .i_negate(cmd_v[2]), .i_pack_float(cmd_v[1]),
      .i_pack_int(cmd_v[0]), .i_mem_word(load_word), .i_arith_sign(ar_s), .i_arith_exp(ar_e),
      .i_arith_frac(ar_f), .o_ready(o_ready), .o_done(o_done), .o_work_sign(o_sign),
      .o_work_exp(o_exp), .o_work_frac(o_frac), .o_zero(o_zero), .o_negative(o_neg),
      .o_mem_word(o_mword), .o_mem_valid(o_mval));

   fofu_host_model u_host (.i_sys_clk(clk), .i_rst(rst), .i_operand(op), .i_store_word(o_mword),
      .i_store_valid(o_mval), .o_load_word(load_word), .o_captured(captured));

   // Verdict and end of run
   task conclude;
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   // Compare one value against its expectation
   task chk(input logic [63:0] seen, input logic [63:0] expv);
      tests_run++;
      if (seen !== expv)
      begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask : chk

   // Working word against sign, exponent and fraction
   task chkw(input logic es, input logic [7:0] ee, input logic [63:0] ef);
      chk({63'h0, o_sign}, {63'h0, es});
      chk({56'h0, o_exp}, {56'h0, ee});
      chk(o_frac, ef);
      chk({62'h0, o_zero, o_neg}, {62'h0, ef == 64'h0, es && ef != 64'h0});
   endtask : chkw

   // One command pulse, then wait for its answer and check the latency
   task cmd(input int k, input int lat);
      int n;
      @(posedge clk);
      #1 cmd_v = 6'h1 << k;
      @(posedge clk);
      #1 cmd_v = '0;
      n = 0;
      while (!(o_done === 1'b1 || o_mval === 1'b1) && n < 4)
      begin
         @(posedge clk);
         #1 n++;
      end
      chk(64'(n), 64'(lat));
   endtask : cmd

   // Reference normalizer: overflow shifts right, leading zeros shift left
   task automatic norm(input logic [63:0] fi, input logic [7:0] ei,
                       output logic [63:0] fo, output logic [7:0] eo);
      fo = fi;
      eo = ei;
      if (fi[63])
      begin
         fo = fi >> 1;
         eo = ei + 8'h01;
      end
      else
         while (fo != 0 && !fo[62])
         begin
            fo = fo << 1;
            eo = eo - 8'h01;
         end
   endtask : norm

   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         conclude();
      end
   end

   // Main sequence
   initial
   begin
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      chk({62'h0, o_ready, o_zero}, 64'h3);
      chk(o_frac, 64'h0);
      for (int i = 0; i < 8; i++)
      begin
         dp = i[0];
         li = i[1];
         // Float load, optional negate, store
         w = {$random(seed), $random(seed)};
         if (i == 5)
         begin
            w[62:55] = 8'h00;
            w[30:23] = 8'h00;
         end
         e = dp ? w[62:55] : w[30:23];
         s = dp ? w[63] : w[31];
         f = dp ? {2'b01, w[54:0], 7'h0} : {2'b01, w[22:0], 39'h0};
         mem = dp ? w : {32'h0, w[31:0]};
         if (e == 8'h00)
         begin
            {s, f, mem} = '0;
         end
         op = w;
         cmd(5, 1);
         chkw(s, e, f);
         if (e != 8'h00)
         begin
            cmd(2, 0);
            s = ~s;
            mem = mem ^ (dp ? 64'h8000000000000000 : 64'h80000000);
            chkw(s, e, f);
         end
         cmd(1, 0);
         chk(o_mword, mem);
         // Host memory takes the word one edge after the strobe
         @(posedge clk);
         #1 chk(captured, mem);
         // Integer load and store round trip
         v = $random(seed);
         if (i == 3)
            v = 32'h80000000;
         if (!li)
            v = {{16{v[15]}}, v[15:0]};
         op = {$random(seed), $random(seed)};
         if (li)
            op[31:0] = v;
         else
            op[15:0] = v[15:0];
         m = v[31] ? {32'h0, -v} : {32'h0, v};
         norm(m, 8'hbf, nf, ne);
         if (v == 0)
            ne = 8'h00;
         cmd(4, 1);
         chkw(v[31], ne, nf);
         cmd(0, 0);
         chk(o_mword, li ? {32'h0, v} : {48'h0, v[15:0]});
         // Arithmetic result with overflow or leading zeros
         ar_f = {$random(seed), $random(seed)} | 64'h1;
         ar_e = 8'($random(seed));
         ar_s = 1'($random(seed));
         if (i[2])
            ar_f[63] = 1'b1;
         else
            ar_f = (ar_f >> (i * 7)) & 64'h7fffffffffffffff;
         norm(ar_f, ar_e, nf, ne);
         cmd(3, 1);
         chkw(ar_s, ne, nf);
      end
      // Reset in mid-run clears a nonzero working word
      @(posedge clk);
      #1 rst = 1'b1;
      @(posedge clk);
      #1 rst = 1'b0;
      chk(o_frac, 64'h0);
      chk({56'h0, o_exp}, 64'h0);
      chk({62'h0, o_ready, o_sign}, 64'h2);
      conclude();
   end
endmodule : fofu_format_unit_tb
